// ### pkg/swl_pkg.sv
// Package: timing, commands and types shared by both ends of the single-wire slot link
package swl_pkg;
	localparam int CLK_MHZ = 25;                     // Core clock rate, MHz
	localparam int US_NS   = 1000;                   // One microsecond in ns
	localparam int CLK_NS  = US_NS / CLK_MHZ;        // Clock period, 40 ns
	localparam logic [4:0] US_LAST = 5'(US_NS / CLK_NS - 1); // Microsecond divider end count
	// Host timing in microseconds (counter value at which a phase ends)
	localparam logic [9:0] RST_LOW_US  = 10'h1e0;    // Reset low, 480
	localparam logic [9:0] RST_REL_US  = 10'h1e0;    // Listen after reset, 480
	localparam logic [9:0] PRES_MIN_US = 10'h00f;    // Presence window start, 15
	localparam logic [9:0] PRES_MAX_US = 10'h12c;    // Presence window end, 300
	localparam logic [9:0] SLOT_US     = 10'h041;    // Slot length, 65
	localparam logic [9:0] REC_US      = 10'h002;    // Recovery, 2
	localparam logic [9:0] W1_LOW_US   = 10'h006;    // Write-one low time, 6
	localparam logic [9:0] W0_LOW_US   = 10'h03e;    // Write-zero low time, 62
	localparam logic [9:0] RD_LOW_US   = 10'h002;    // Read slot opening low, 2
	localparam logic [9:0] RD_SAMP_US  = 10'h00c;    // Read sample point, 12
	// Device timing in microseconds
	localparam logic [9:0] DEV_RST_DET_US   = 10'h12c; // Low time taken as reset, 300
	localparam logic [9:0] DEV_PRES_WAIT_US = 10'h01e; // Wait before presence, 30
	localparam logic [9:0] DEV_PRES_LEN_US  = 10'h078; // Presence end, 120, counted from the device's own fall, so it lasts 121
	localparam logic [9:0] DEV_SAMP_US      = 10'h01e; // Write sample point, 30
	localparam logic [9:0] DEV_RD_HOLD_US   = 10'h01e; // Read-zero hold, 30
	localparam logic [9:0] T_SAT            = 10'h3ff; // Saturation of slot timer
	// Commands
	localparam logic [7:0] CMD_MATCH    = 8'h55;     // Select by serial
	localparam logic [7:0] CMD_SKIP     = 8'hcc;     // Select all
	localparam logic [7:0] CMD_CONVERT  = 8'h44;     // Start conversion
	localparam logic [7:0] CMD_READ_MEM = 8'hbe;     // Read work memory
	localparam logic [7:0] restore_from_nvm_cmd = 8'hb8; // Restore from nonvolatile
	localparam logic [7:0] CRC_POLY     = 8'h8c;     // Reflected x^8+x^5+x^4+1
	// Bit counts
	localparam logic [6:0] CMD_LAST = 7'h07;         // Last bit of a command byte
	localparam logic [6:0] ROM_LAST = 7'h3f;         // Last bit of the 64-bit serial
	localparam logic [6:0] MEM_LAST = 7'h47;         // Last bit of 9 memory bytes
	localparam logic [6:0] TX_LAST  = 7'h4f;         // Last bit of select plus command
	// Host operations
	typedef enum logic [1:0] {OP_CONVERT, OP_READ, OP_RESTORE} swl_op_t;

	// Function command byte for a host operation
	function automatic logic [7:0] swl_fcmd(input swl_op_t op);
		unique case (op)
			OP_CONVERT: swl_fcmd = CMD_CONVERT;
			OP_READ:    swl_fcmd = CMD_READ_MEM;
			default:    swl_fcmd = restore_from_nvm_cmd;
		endcase
	endfunction : swl_fcmd
endpackage : swl_pkg

// ### pkg/swl_if.sv
// Interface: shared open-drain data line with strong pullup between host and device
`timescale 1ns/1ps
`default_nettype none
interface swl_if;
	logic m_out; // Host output level
	logic m_oe;  // Host pulls the line
	logic spu;   // Host strong pullup on
	logic d_out; // Device output level
	logic d_oe;  // Device pulls the line
	logic line;  // Resolved line, high when released
	// Wired-AND with pullup: low whenever an enabled driver drives low
	assign line = ~((m_oe & ~m_out) | (d_oe & ~d_out));
	modport host (output m_out, output m_oe, output spu, input line);
	modport dev  (output d_out, output d_oe, input line, input spu);
endinterface : swl_if
`default_nettype wire

// ### logic/swl_dev.sv
// Device end: presence, write sampling, select, read replies and restore status
`timescale 1ns/1ps
`default_nettype none
module swl_dev import swl_pkg::*; #(
	parameter logic [63:0] ROM_ID = 64'h0123456789abcdef // Serial, arbitrary value
) (
	input  wire logic        clk,           // Core clock
	input  wire logic        arst_n,        // Async reset, active low
	swl_if.dev               link,          // Line side
	input  wire logic [71:0] mem_data,      // Nine memory bytes, byte 0 low
	input  wire logic        restore_busy,  // Restore still running
	output logic             conv_start,    // Conversion start pulse
	output logic             restore_start, // Restore start pulse
	output logic             selected       // Addressed after select
);
	typedef enum logic [2:0] {D_IDLE, D_PRES_WAIT, D_PRES_DRV, D_ROMCMD, D_ROMID,
		D_FCMD, D_TX, D_POLL} swl_dst_t;
	swl_dst_t    st_q;   // Protocol state
	logic        line_q; // Line one cycle ago
	logic [4:0]  div_q;  // Microsecond divider
	logic [9:0]  t_q;    // Microseconds since last edge of interest
	logic        rst_q;  // Long low seen, reset pending
	logic [63:0] rx_q;   // Received bits, LSB first
	logic [71:0] tx_q;   // Bits left to send
	logic [6:0]  n_q;    // Bit counter
	logic        fall;   // Falling edge
	logic        rise;   // Rising edge
	logic        tick;   // One-microsecond enable
	logic        samp;   // Write sample instant
	logic [63:0] rx_nx;  // Receive word with current bit

	assign fall  = line_q & ~link.line;
	assign rise  = ~line_q & link.line;
	assign tick  = (div_q == US_LAST);
	assign samp  = tick && (t_q == DEV_SAMP_US);
	assign rx_nx = {link.line, rx_q[63:1]};
	assign selected = (st_q == D_FCMD) || (st_q == D_TX) || (st_q == D_POLL);
	assign link.d_out = 1'b0;
	// Pull low for presence, for zero bits in read slots and for restore busy in poll slots
	assign link.d_oe = (st_q == D_PRES_DRV) ||
		(st_q == D_TX && !tx_q[0] && t_q < DEV_RD_HOLD_US) ||
		(st_q == D_POLL && restore_busy && t_q < DEV_RD_HOLD_US);

	// Timebase restarted by each falling edge and by the end of a reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			line_q <= 1'b1;
			div_q  <= '0;
			t_q    <= T_SAT;
		end else begin
			line_q <= link.line;
			if (fall || (rise && rst_q)) begin
				div_q <= '0;
				t_q   <= '0;
			end else begin
				div_q <= tick ? '0 : div_q + 5'h01;
				if (tick && t_q != T_SAT)
					t_q <= t_q + 10'h001;
			end
		end
	end

	// Reset detection: a long low, closed by the rising edge
	// The timer is trusted only once the fall has restarted it, so a slot after a long idle
	// is not taken for a reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_q <= 1'b0;
		else if (!link.line && !line_q && t_q >= DEV_RST_DET_US)
			rst_q <= 1'b1;
		else if (rise)
			rst_q <= 1'b0;
	end

	// Protocol sequence from presence through command handling
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q          <= D_IDLE;
			rx_q          <= '0;
			tx_q          <= '0;
			n_q           <= '0;
			conv_start    <= 1'b0;
			restore_start <= 1'b0;
		end else begin
			conv_start    <= 1'b0;
			restore_start <= 1'b0;
			if (rise && rst_q) begin
				st_q <= D_PRES_WAIT;
			end else begin
				unique case (st_q)
					D_IDLE: begin
						// Silent until the next reset
					end
					D_PRES_WAIT: if (tick && t_q == DEV_PRES_WAIT_US)
						st_q <= D_PRES_DRV;
					D_PRES_DRV: if (tick && t_q == DEV_PRES_LEN_US) begin
						st_q <= D_ROMCMD;
						n_q  <= '0;
					end
					D_ROMCMD, D_ROMID, D_FCMD: if (samp) begin
						rx_q <= rx_nx;
						n_q  <= n_q + 7'h01;
						if (st_q == D_ROMID && n_q == ROM_LAST) begin
							n_q  <= '0;
							st_q <= (rx_nx == ROM_ID) ? D_FCMD : D_IDLE;
						end else if (st_q != D_ROMID && n_q == CMD_LAST) begin
							n_q  <= '0;
							st_q <= D_IDLE;
							if (st_q == D_ROMCMD) begin
								if (rx_nx[63:56] == CMD_MATCH)
									st_q <= D_ROMID;
								else if (rx_nx[63:56] == CMD_SKIP)
									st_q <= D_FCMD;
							end else if (rx_nx[63:56] == CMD_CONVERT) begin
								conv_start <= 1'b1;
							end else if (rx_nx[63:56] == CMD_READ_MEM) begin
								st_q <= D_TX;
								tx_q <= mem_data;
							end else if (rx_nx[63:56] == restore_from_nvm_cmd) begin
								st_q          <= D_POLL;
								restore_start <= 1'b1;
							end
						end
					end
					D_TX: if (tick && t_q == DEV_RD_HOLD_US) begin
						tx_q <= tx_q >> 1;
						n_q  <= n_q + 7'h01;
						if (n_q == MEM_LAST)
							st_q <= D_IDLE;
					end
					D_POLL: begin
						// Status answered by the line drive until reset
					end
				endcase
			end
		end
	end
endmodule : swl_dev
`default_nettype wire

// ### logic/swl_host.sv
// Host end: reset, slot timing, select, conversion, memory read with CRC, restore poll
`timescale 1ns/1ps
`default_nettype none
module swl_host import swl_pkg::*; #(
	parameter int CONV_US   = 750000, // Strong pullup hold, us
	parameter int RETRY_MAX = 3,      // Memory read retries on CRC error
	parameter int POLL_MAX  = 1000    // Restore status slots before giving up
) (
	input  wire logic        clk,          // Core clock
	input  wire logic        arst_n,       // Async reset, active low
	swl_if.host              link,         // Line side
	input  wire logic        op_valid,     // Operation request
	output logic             op_ready,     // Ready for an operation
	input  wire swl_op_t     op_code,      // Operation kind
	input  wire logic [63:0] op_rom,       // Serial of target device
	output logic             done,         // Operation finished pulse
	output logic             present,      // Presence seen
	output logic             crc_ok,       // Memory CRC matched
	output logic             restore_done, // Restore reported finished
	output logic [71:0]      mem_out       // Memory bytes, byte 0 low
);
	localparam logic [19:0] CONV_END  = 20'(CONV_US);   // Pullup end count
	localparam logic [7:0]  RETRY_END = 8'(RETRY_MAX);  // Retry limit
	localparam logic [15:0] POLL_END  = 16'(POLL_MAX - 1); // Last poll slot

	typedef enum logic [1:0] {K_RST, K_W0, K_W1, K_RD} swl_kind_t;
	typedef enum logic [2:0] {SL_IDLE, SL_RLOW, SL_RREL, SL_BIT, SL_REC} swl_sl_t;
	typedef enum logic [2:0] {SQ_IDLE, SQ_RST, SQ_TX, SQ_SPU, SQ_RX, SQ_POLL} swl_sq_t;

	swl_sl_t     sl_q;      // Slot engine state
	swl_kind_t   kind_q;    // Kind of running slot
	logic [9:0]  t_q;       // Microseconds into phase
	logic [4:0]  div_q;     // Microsecond divider
	logic        val_q;     // Presence or read bit of slot
	swl_sq_t     sq_q;      // Sequencer state
	swl_op_t     op_q;      // Operation in progress
	logic [63:0] rom_q;     // Target serial
	logic [79:0] tx_q;      // Bits left to send
	logic [71:0] rx_q;      // Received bits
	logic [6:0]  n_q;       // Bit counter
	logic [7:0]  retry_q;   // Retries used
	logic [19:0] conv_q;    // Pullup microseconds
	logic [15:0] poll_q;    // Poll slots used
	logic        tick;      // One-microsecond enable
	logic        slot_go;   // Start a slot
	swl_kind_t   slot_kind; // Kind of slot to start
	logic        slot_done; // Slot ends this cycle
	logic [9:0]  low_len;   // Low time of bit slot
	logic [71:0] rx_nx;     // Receive word with current bit

	// Eight-bit CRC over 64 bits, LSB first
	function automatic logic [7:0] swl_crc8(input logic [63:0] d);
		logic [7:0] c;
		logic       fb;
		c = '0;
		for (int i = 0; i < 64; i++) begin
			fb = c[0] ^ d[i];
			c  = c >> 1;
			if (fb)
				c = c ^ CRC_POLY;
		end
		return c;
	endfunction : swl_crc8

	assign tick      = (div_q == US_LAST);
	assign op_ready  = (sq_q == SQ_IDLE);
	assign rx_nx     = {val_q, rx_q[71:1]};
	assign slot_go   = (sl_q == SL_IDLE) && (sq_q == SQ_RST || sq_q == SQ_TX ||
		sq_q == SQ_RX || sq_q == SQ_POLL);
	assign slot_done = tick && ((sl_q == SL_RREL && t_q == RST_REL_US) ||
		(sl_q == SL_REC && t_q == REC_US));

	// Slot kind follows the sequencer; data bits go out LSB first
	always_comb begin
		if (sq_q == SQ_RST)
			slot_kind = K_RST;
		else if (sq_q == SQ_TX)
			slot_kind = tx_q[0] ? K_W1 : K_W0;
		else
			slot_kind = K_RD;
	end

	// Low time per slot kind
	always_comb begin
		unique case (kind_q)
			K_W0:    low_len = W0_LOW_US;
			K_W1:    low_len = W1_LOW_US;
			default: low_len = RD_LOW_US;
		endcase
	end

	assign link.m_out = 1'b0;
	assign link.m_oe  = (sl_q == SL_RLOW) || (sl_q == SL_BIT && t_q < low_len);
	assign link.spu   = (sq_q == SQ_SPU);

	// Microsecond divider, realigned at each slot start
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			div_q <= '0;
		else if (slot_go || tick)
			div_q <= '0;
		else
			div_q <= div_q + 5'h01;
	end

	// Slot engine: reset and presence listen, bit slots, recovery
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sl_q   <= SL_IDLE;
			kind_q <= K_RST;
			t_q    <= '0;
			val_q  <= 1'b0;
		end else begin
			if (tick)
				t_q <= t_q + 10'h001;
			unique case (sl_q)
				SL_IDLE: if (slot_go) begin
					sl_q   <= (slot_kind == K_RST) ? SL_RLOW : SL_BIT;
					kind_q <= slot_kind;
					t_q    <= '0;
					val_q  <= 1'b0;
				end
				SL_RLOW: if (tick && t_q == RST_LOW_US) begin
					sl_q <= SL_RREL;
					t_q  <= '0;
				end
				SL_RREL: begin
					// Presence is any low inside the listen window
					if (!link.line && t_q >= PRES_MIN_US && t_q <= PRES_MAX_US)
						val_q <= 1'b1;
					if (tick && t_q == RST_REL_US)
						sl_q <= SL_IDLE;
				end
				SL_BIT: begin
					if (kind_q == K_RD && tick && t_q == RD_SAMP_US)
						val_q <= link.line;
					if (tick && t_q == SLOT_US) begin
						sl_q <= SL_REC;
						t_q  <= '0;
					end
				end
				SL_REC: if (tick && t_q == REC_US)
					sl_q <= SL_IDLE;
			endcase
		end
	end

	// Sequencer: select, command, then pullup, memory read or restore poll
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sq_q         <= SQ_IDLE;
			op_q         <= OP_CONVERT;
			rom_q        <= '0;
			tx_q         <= '0;
			rx_q         <= '0;
			n_q          <= '0;
			retry_q      <= '0;
			conv_q       <= '0;
			poll_q       <= '0;
			done         <= 1'b0;
			present      <= 1'b0;
			crc_ok       <= 1'b0;
			restore_done <= 1'b0;
			mem_out      <= '0;
		end else begin
			done <= 1'b0;
			unique case (sq_q)
				SQ_IDLE: if (op_valid) begin
					op_q    <= op_code;
					rom_q   <= op_rom;
					tx_q    <= {swl_fcmd(op_code), op_rom, CMD_MATCH};
					n_q     <= '0;
					retry_q <= '0;
					sq_q    <= SQ_RST;
				end
				SQ_RST: if (slot_done) begin
					present <= val_q;
					if (val_q) begin
						sq_q <= SQ_TX;
					end else begin
						sq_q <= SQ_IDLE;
						done <= 1'b1;
					end
				end
				SQ_TX: if (slot_done) begin
					tx_q <= tx_q >> 1;
					n_q  <= n_q + 7'h01;
					if (n_q == TX_LAST) begin
						n_q    <= '0;
						conv_q <= '0;
						poll_q <= '0;
						unique case (op_q)
							OP_CONVERT: sq_q <= SQ_SPU;
							OP_READ:    sq_q <= SQ_RX;
							default:    sq_q <= SQ_POLL;
						endcase
					end
				end
				SQ_SPU: if (tick) begin
					conv_q <= conv_q + 20'h00001;
					if (conv_q == CONV_END) begin
						sq_q <= SQ_IDLE;
						done <= 1'b1;
					end
				end
				SQ_RX: if (slot_done) begin
					rx_q <= rx_nx;
					n_q  <= n_q + 7'h01;
					if (n_q == MEM_LAST) begin
						n_q     <= '0;
						mem_out <= rx_nx;
						crc_ok  <= (swl_crc8(rx_nx[63:0]) == rx_nx[71:64]);
						if (swl_crc8(rx_nx[63:0]) == rx_nx[71:64] || retry_q == RETRY_END) begin
							sq_q <= SQ_IDLE;
							done <= 1'b1;
						end else begin
							retry_q <= retry_q + 8'h01;
							tx_q    <= {swl_fcmd(op_q), rom_q, CMD_MATCH};
							sq_q    <= SQ_RST;
						end
					end
				end
				SQ_POLL: if (slot_done) begin
					poll_q       <= poll_q + 16'h0001;
					restore_done <= val_q;
					if (val_q || poll_q == POLL_END) begin
						sq_q <= SQ_IDLE;
						done <= 1'b1;
					end
				end
				default: sq_q <= SQ_IDLE;
			endcase
		end
	end
endmodule : swl_host
`default_nettype wire

// ### tb/swl_link_sva.sv
// Checker: line timing between the host and device ends of the single-wire link
`timescale 1ns/1ps
`default_nettype none
module swl_link_sva (
	input  wire logic clk,    // Core clock
	input  wire logic arst_n, // Async reset, active low
	input  wire logic m_out,  // Host output level
	input  wire logic m_oe,   // Host pulls the line
	input  wire logic spu,    // Host strong pullup
	input  wire logic d_out,  // Device output level
	input  wire logic d_oe,   // Device pulls the line
	input  wire logic line    // Resolved line
);
	logic        m_q;   // Host enable, last cycle
	logic [15:0] m_cnt; // Cycles the host has pulled low
	logic [15:0] d_cnt; // Cycles the device has pulled low
	logic [15:0] h_cnt; // Cycles the line has stayed high
	logic [15:0] s_cnt; // Cycles since the host last began a low
	logic [15:0] r_cnt; // Cycles since the host last released

	// Saturating step, so long idles never wrap into a short count
	function automatic logic [15:0] inc(input logic [15:0] v);
		inc = (v == 16'hffff) ? v : v + 16'h0001;
	endfunction : inc

	// Run lengths and distances from host edges; idle counts start saturated
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			m_q   <= 1'b0;
			m_cnt <= 16'h0000;
			d_cnt <= 16'h0000;
			h_cnt <= 16'hffff;
			s_cnt <= 16'hffff;
			r_cnt <= 16'hffff;
		end else begin
			m_q   <= m_oe;
			m_cnt <= m_oe ? inc(m_cnt) : 16'h0000;
			d_cnt <= d_oe ? inc(d_cnt) : 16'h0000;
			h_cnt <= line ? inc(h_cnt) : 16'h0000;
			s_cnt <= (m_oe && !m_q) ? 16'h0001 : inc(s_cnt);
			r_cnt <= (!m_oe && m_q) ? 16'h0001 : inc(r_cnt);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Host lows: short opening, write zero, or full reset
	property p_host_low;
		$fell(m_oe) |-> m_cnt inside {[16'd25:16'd375], [16'd1500:16'd1650], [16'd12000:16'hffff]};
	endproperty
	a_host_low: assert property (p_host_low) else $error("host low time out of range");
	// Released line before each new slot
	property p_recovery;
		$rose(m_oe) |-> h_cnt >= 16'd25;
	endproperty
	a_recovery: assert property (p_recovery) else $error("recovery too short");
	// Slot start to slot start
	property p_slot_len;
		$rose(m_oe) |-> s_cnt >= 16'd1525;
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot too short");
	// Device starts a low on a high line only as presence
	property p_pres_start;
		$rose(d_oe) && $past(line) |-> r_cnt inside {[16'd375:16'd1500]};
	endproperty
	a_pres_start: assert property (p_pres_start) else $error("presence start off");
	// Read zero or presence length
	property p_drive_len;
		$fell(d_oe) |-> d_cnt inside {[16'd360:16'd1450], [16'd1500:16'd6000]};
	endproperty
	a_drive_len: assert property (p_drive_len) else $error("device low length off");
	// Device answers only right after a host-opened slot
	property p_read_reply;
		$rose(d_oe) && !$past(line) |-> s_cnt <= 16'd4;
	endproperty
	a_read_reply: assert property (p_read_reply) else $error("device reply late");
	// Pullup follows the last command slot closely
	property p_spu_start;
		$rose(spu) |-> r_cnt <= 16'd250;
	endproperty
	a_spu_start: assert property (p_spu_start) else $error("pullup late");
	// Nobody pulls while the pullup is on
	property p_spu_quiet;
		spu |-> !m_oe && !d_oe;
	endproperty
	a_spu_quiet: assert property (p_spu_quiet) else $error("line pulled under pullup");
	// Drivers only ever pull low
	property p_drive_low;
		(m_oe || d_oe) |-> !(m_oe && m_out) && !(d_oe && d_out);
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("line driven high");
endmodule : swl_link_sva
`default_nettype wire

// ### tb/testbench.sv
// Testbench: host and device ends joined on one line, operations checked end to end
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; \
	if ((got) !== (exp)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, (exp), (got)); end end
module testbench import swl_pkg::*; ;
	localparam int CONV_T  = 20;      // Shortened pullup hold, us
	localparam int RETRY_T = 1;       // Memory read retries
	localparam int POLL_T  = 5;       // Restore status slots
	localparam int CYC_MAX = 2500000; // Watchdog, clock cycles
	localparam logic [63:0] DEV_ROM  = 64'h5a3c96e10f7b2d48; // Serial, arbitrary value
	localparam logic [63:0] MEM_BODY = 64'h0b1f4b467fff0a91; // Memory bytes 0..7
	logic        clk;           // Core clock
	logic        arst_n;        // Async reset
	logic        op_valid;      // Operation request
	swl_op_t     op_code;       // Operation kind
	logic [63:0] op_rom;        // Target serial
	logic [71:0] mem_data;      // Device memory image
	logic        restore_busy;  // Restore running
	logic        op_ready;      // Host idle
	logic        done;          // Operation finished
	logic        present;       // Presence seen
	logic        crc_ok;        // Check byte matched
	logic        restore_done;  // Restore finished
	logic [71:0] mem_out;       // Bytes read
	logic        conv_start;    // Conversion start pulse
	logic        restore_start; // Restore start pulse
	logic        selected;      // Device addressed
	logic [71:0] mem_good;      // Image with correct check byte
	logic [71:0] mem_bad;       // Image with broken check byte
	int          err_count;     // Mismatches
	int          tests_run;     // Comparisons
	int          cyc;           // Watchdog count
	int          conv_cnt;      // Start pulses in this operation
	int          rest_cnt;      // Restore pulses in this operation
	int          spu_cnt;       // Pullup cycles in this operation
	int          op_cyc;        // Operation length, cycles
	int          good_cyc;      // Length of a clean read

	swl_if swl_if_inst ();
	swl_host #(.CONV_US(CONV_T), .RETRY_MAX(RETRY_T), .POLL_MAX(POLL_T)) swl_host_inst (
		.clk(clk), .arst_n(arst_n), .link(swl_if_inst), .op_valid(op_valid),
		.op_ready(op_ready), .op_code(op_code), .op_rom(op_rom), .done(done),
		.present(present), .crc_ok(crc_ok), .restore_done(restore_done), .mem_out(mem_out));
	swl_dev #(.ROM_ID(DEV_ROM)) swl_dev_inst (
		.clk(clk), .arst_n(arst_n), .link(swl_if_inst), .mem_data(mem_data),
		.restore_busy(restore_busy), .conv_start(conv_start),
		.restore_start(restore_start), .selected(selected));
	swl_link_sva swl_link_sva_inst (
		.clk(clk), .arst_n(arst_n), .m_out(swl_if_inst.m_out), .m_oe(swl_if_inst.m_oe),
		.spu(swl_if_inst.spu), .d_out(swl_if_inst.d_out), .d_oe(swl_if_inst.d_oe),
		.line(swl_if_inst.line));

	// Reference check byte, LSB first, reflected polynomial
	function automatic logic [7:0] ref_crc(input logic [63:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			fb = c[0] ^ d[i];
			c = c >> 1;
			if (fb) begin
				c = c ^ 8'h8c;
			end
		end
		return c;
	endfunction : ref_crc

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	// One host operation: offer, then wait for the done pulse
	task automatic run_op(input swl_op_t op, input logic [63:0] rom);
		@(negedge clk);
		`CHK("op_ready", 1'b1, op_ready)
		conv_cnt = 0;
		rest_cnt = 0;
		spu_cnt = 0;
		op_cyc = 0;
		op_valid = 1'b1;
		op_code = op;
		op_rom = rom;
		@(negedge clk);
		op_valid = 1'b0;
		do begin
			@(negedge clk);
			op_cyc++;
		end while (done !== 1'b1);
		@(negedge clk);
	endtask : run_op

	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulse counters and watchdog
	always @(posedge clk) begin
		cyc++;
		if (conv_start === 1'b1) conv_cnt++;
		if (restore_start === 1'b1) rest_cnt++;
		if (swl_if_inst.spu === 1'b1) spu_cnt++;
		if (cyc >= CYC_MAX) begin
			err_count++;
			tally_and_finish;
		end
	end

	// Main sequence
	initial begin
		arst_n = 1'b0;
		op_valid = 1'b0;
		op_code = OP_CONVERT;
		op_rom = DEV_ROM;
		mem_data = 72'h0;
		restore_busy = 1'b0;
		mem_good = {ref_crc(MEM_BODY), MEM_BODY};
		mem_bad = mem_good ^ {8'h01, 64'h0};
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		// Convert on the matching serial
		run_op(OP_CONVERT, DEV_ROM);
		`CHK("present", 1'b1, present)
		`CHK("conv_start", 1, conv_cnt)
		`CHK("pullup held", 1'b1, spu_cnt >= CONV_T * 25)
		// Memory read with a good check byte
		mem_data = mem_good;
		run_op(OP_READ, DEV_ROM);
		good_cyc = op_cyc;
		`CHK("mem_out", mem_good, mem_out)
		`CHK("crc_ok", 1'b1, crc_ok)
		`CHK("conv_start read", 0, conv_cnt)
		// Broken check byte: read repeated, then reported bad
		mem_data = mem_bad;
		run_op(OP_READ, DEV_ROM);
		`CHK("crc_ok bad", 1'b0, crc_ok)
		`CHK("mem_out bad", mem_bad, mem_out)
		`CHK("read repeated", 1'b1, op_cyc >= good_cyc + 72 * 61 * 25)
		// Other serial: presence, yet no conversion start
		run_op(OP_CONVERT, ~DEV_ROM);
		`CHK("present other", 1'b1, present)
		`CHK("conv_start other", 0, conv_cnt)
		`CHK("selected other", 1'b0, selected)
		// Restore busy on every poll, then finished
		restore_busy = 1'b1;
		run_op(OP_RESTORE, DEV_ROM);
		`CHK("restore_start", 1, rest_cnt)
		`CHK("selected restore", 1'b1, selected)
		`CHK("restore_done busy", 1'b0, restore_done)
		restore_busy = 1'b0;
		run_op(OP_RESTORE, DEV_ROM);
		`CHK("restore_done", 1'b1, restore_done)
		tally_and_finish;
	end
endmodule : testbench
`default_nettype wire
